// *** src/tshc_pkg.sv ***
// shared constants and types for the thermistor scan and heater sequencer
package tshc_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int PWM_HZ = 10;
    localparam int SETTLE_US = 1000;
    localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int N_SLOT = 19;
    localparam int N_CH = 16;
    localparam int N_GRP = 5;
    localparam int AVG_LOG2 = 8;
    localparam int SUM_W = 16 + AVG_LOG2;
    localparam logic [11:0] SP_ZERO = 12'h0_064;
    localparam logic [11:0] SP_FULL = 12'h0_FA0;
    localparam int DUTY_STEPS = 3900;
    localparam int PWM_PRESCALE = CLK_HZ / (PWM_HZ * DUTY_STEPS);
    localparam logic signed [15:0] AR_LOW = 16'sh9_000;
    localparam logic signed [15:0] AR_HIGH = 16'sh7_000;
    localparam logic [2:0] OFF_MAX_AR = 3'h3;
    localparam logic [2:0] OFF_RST = 3'h1;
    localparam logic [11:0] SP_AMB_RST = 12'h0_72E;
    localparam logic [11:0] SP_HOT_RST = 12'h0_86D;
    localparam logic [11:0] SP_AMB_MIN = 12'h0_064;
    localparam logic [11:0] SP_AMB_MAX = 12'h0_F00;
    localparam logic [11:0] SP_HOT_MIN = 12'h0_064;
    localparam logic [11:0] SP_HOT_MAX = 12'h0_F00;
    localparam logic [3:0] CH_CAL_A = 4'hC;
    localparam int SLOT_SECOND = 16;
    localparam int GRP_AMB = 0;
    localparam int GRP_HOT = 1;

    // group index: 0 ambient, 1 hot, 2..4 spare channels one to three
    typedef struct packed {
        logic [1:0] const_pwr;
        logic [1:0] therm_b;
        logic [1:0][11:0] setpoint;
        logic [N_GRP-1:0][2:0] offset;
        logic [N_GRP-1:0] ar_en;
    } tshc_cfg_t;

    typedef enum logic [4:0] {
        S_SETUP = 5'b00001,
        S_SETTLE = 5'b00010,
        S_CONV = 5'b00100,
        S_STORE = 5'b01000,
        S_END = 5'b10000
    } tshc_state_t;
endpackage

// *** src/tshc_scan.sv ***
// scan sequencer, offset autoranging, heater pwm and overtemperature latch
// Behaviour
// - control thermistor comes only from host command, never switched automatically
// - heater pwm runs near 10 Hz, free of the scan timing
// - constant power: set point sets duty, zero duty at or below low limit
// - constant power: full duty at upper limit, step finer than 0.03 percent
// - constant temperature: out-of-range set point commands are refused
// - overtemperature comparator removes heater drive, restores it when it clears
// - overtemperature indicator latches until reset or new host command
// - each source has its own protection and indicator
// - ambient channels share an offset, hot channels another, spares their own
// - five offset codes selectable, zero offset code allowed everywhere
// - per channel: offset, mux, settle, average 256 conversions, store, next
// - averaged result is 16-bit two's complement
// - autorange enable per group and spare, never for calibration channels
// - ambient autorange uses channel 0, hot autorange uses channel 4
// - step offset up below low threshold, down above high threshold
// - autorange uses codes 0 to 3, one step per collection
// - calibration channels 11 and 15 use one fixed offset
// - calibration channels 12 to 14 measured twice, 19 results kept
// - spare error channels use offset code 4 when commanded
// - host command settings take effect only at end of sampling interval; the overtemperature indicator clears on command arrival
`timescale 1ns/1ps
`default_nettype none
module tshc_scan #(
    parameter int SETTLE_CYC = tshc_pkg::SETTLE_CYC,
    parameter int PWM_PRESCALE = tshc_pkg::PWM_PRESCALE
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // host command
    input wire logic i_cmd_valid,
    input wire tshc_pkg::tshc_cfg_t i_cmd,
    output logic o_cmd_refused,
    output tshc_pkg::tshc_cfg_t o_cfg,
    // analog front end
    output logic [3:0] o_mux_ch,
    output logic [2:0] o_offset,
    output logic o_adc_start,
    input wire logic i_adc_valid,
    input wire logic signed [15:0] i_adc_data,
    // results
    output logic [tshc_pkg::N_SLOT-1:0][15:0] o_result,
    output logic o_scan_done,
    // heaters
    input wire logic [1:0] i_pid_heat,
    input wire logic [1:0] i_overtemp,
    output logic [1:0] o_heater,
    output logic [1:0] o_overtemp_flag
);
    tshc_pkg::tshc_state_t state_r, state_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic [31:0] wait_r, wait_nxt;
    logic [tshc_pkg::AVG_LOG2-1:0] cnt_r, cnt_nxt;
    logic [tshc_pkg::SUM_W-1:0] sum_r, sum_nxt;
    logic [tshc_pkg::N_SLOT-1:0][15:0] res_r, res_nxt;
    logic start_r, start_nxt;
    tshc_pkg::tshc_cfg_t cfg_r, cfg_nxt, pend_r, pend_nxt;
    logic pend_v_r, pend_v_nxt, refused_r, refused_nxt;
    logic [31:0] pre_r, pre_nxt;
    logic [11:0] phase_r, phase_nxt;
    logic [1:0] heat_r, heat_nxt, otf_r, otf_nxt;
    logic [3:0] ch;
    logic [2:0] off;

    // slot to multiplexer channel
    function automatic logic [3:0] slot_ch(input logic [4:0] s);
        if (s >= 5'(tshc_pkg::SLOT_SECOND)) begin
            return tshc_pkg::CH_CAL_A + 4'(s - 5'(tshc_pkg::SLOT_SECOND));
        end
        return s[3:0];
    endfunction

    // slot to offset code; calibration codes are fixed by position
    function automatic logic [2:0] slot_off(input logic [4:0] s, input tshc_pkg::tshc_cfg_t c);
        unique case (s)
            5'h00, 5'h01, 5'h02, 5'h03: return c.offset[tshc_pkg::GRP_AMB];
            5'h04, 5'h05, 5'h06, 5'h07: return c.offset[tshc_pkg::GRP_HOT];
            5'h08: return c.offset[2];
            5'h09: return c.offset[3];
            5'h0A: return c.offset[4];
            5'h0B, 5'h0C: return 3'h3;
            5'h0D, 5'h10: return 3'h2;
            5'h0E, 5'h11: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction

    // one autorange step, only inside codes 0..3
    function automatic logic [2:0] ar_step(input logic [2:0] o, input logic [15:0] r);
        if (o > tshc_pkg::OFF_MAX_AR) begin
            return o;
        end
        if ($signed(r) < tshc_pkg::AR_LOW && o < tshc_pkg::OFF_MAX_AR) begin
            return o + 3'h1;
        end
        if ($signed(r) > tshc_pkg::AR_HIGH && o != 3'h0) begin
            return o - 3'h1;
        end
        return o;
    endfunction

    // refusal check for constant temperature set points
    function automatic logic sp_bad(input int s, input logic [11:0] v);
        if (s == tshc_pkg::GRP_AMB) begin
            return v < tshc_pkg::SP_AMB_MIN || v > tshc_pkg::SP_AMB_MAX;
        end
        return v < tshc_pkg::SP_HOT_MIN || v > tshc_pkg::SP_HOT_MAX;
    endfunction

    assign ch = slot_ch(slot_r);
    assign off = slot_off(slot_r, cfg_r);

    // scan sequencer
    always_comb begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        wait_nxt = wait_r;
        cnt_nxt = cnt_r;
        sum_nxt = sum_r;
        res_nxt = res_r;
        start_nxt = 1'b0;
        unique case (state_r)
            tshc_pkg::S_SETUP: begin
                wait_nxt = 32'(SETTLE_CYC);
                state_nxt = tshc_pkg::S_SETTLE;
            end
            tshc_pkg::S_SETTLE: begin
                if (wait_r <= 32'h0000_0001) begin
                    state_nxt = tshc_pkg::S_CONV;
                    cnt_nxt = '0;
                    sum_nxt = '0;
                    start_nxt = 1'b1;
                end else begin
                    wait_nxt = wait_r - 32'h0000_0001;
                end
            end
            tshc_pkg::S_CONV: begin
                // back-to-back conversions: next start issued with each result except the 256th
                if (i_adc_valid) begin
                    sum_nxt = sum_r + {{tshc_pkg::AVG_LOG2{i_adc_data[15]}}, i_adc_data};
                    cnt_nxt = cnt_r + 1'b1;
                    if (cnt_r == '1) begin
                        state_nxt = tshc_pkg::S_STORE;
                    end else begin
                        start_nxt = 1'b1;
                    end
                end
            end
            tshc_pkg::S_STORE: begin
                res_nxt[slot_r] = sum_r[tshc_pkg::SUM_W-1 -: 16];
                if (slot_r == 5'(tshc_pkg::N_SLOT - 1)) begin
                    state_nxt = tshc_pkg::S_END;
                end else begin
                    slot_nxt = slot_r + 5'h01;
                    state_nxt = tshc_pkg::S_SETUP;
                end
            end
            tshc_pkg::S_END: begin
                slot_nxt = '0;
                state_nxt = tshc_pkg::S_SETUP;
            end
            default: state_nxt = tshc_pkg::S_SETUP;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= tshc_pkg::S_SETUP;
            slot_r <= '0;
            wait_r <= '0;
            cnt_r <= '0;
            sum_r <= '0;
            res_r <= '0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            wait_r <= wait_nxt;
            cnt_r <= cnt_nxt;
            sum_r <= sum_nxt;
            res_r <= res_nxt;
            start_r <= start_nxt;
        end
    end

    // configuration: commands held pending, applied at end of collection
    always_comb begin
        cfg_nxt = cfg_r;
        pend_nxt = pend_r;
        pend_v_nxt = pend_v_r;
        refused_nxt = 1'b0;
        if (state_r == tshc_pkg::S_END) begin
            // autorange from the group's reference channel only
            if (cfg_r.ar_en[0]) cfg_nxt.offset[0] = ar_step(cfg_r.offset[0], res_r[0]);
            if (cfg_r.ar_en[1]) cfg_nxt.offset[1] = ar_step(cfg_r.offset[1], res_r[4]);
            for (int g = 2; g < tshc_pkg::N_GRP; g++) begin
                if (cfg_r.ar_en[g]) begin
                    cfg_nxt.offset[g] = ar_step(cfg_r.offset[g], res_r[g + 6]);
                end
            end
            if (pend_v_r) begin
                cfg_nxt = pend_r;
                for (int s = 0; s < 2; s++) begin
                    if (!pend_r.const_pwr[s] && sp_bad(s, pend_r.setpoint[s])) begin
                        cfg_nxt.setpoint[s] = cfg_r.setpoint[s];
                        refused_nxt = 1'b1;
                    end
                end
                pend_v_nxt = 1'b0;
            end
        end
        // a command arriving on the apply cycle stays pending for the next interval
        if (i_cmd_valid) begin
            pend_nxt = i_cmd;
            pend_v_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cfg_r.const_pwr <= '0;
            cfg_r.therm_b <= '0;
            cfg_r.setpoint <= {tshc_pkg::SP_HOT_RST, tshc_pkg::SP_AMB_RST};
            cfg_r.offset <= {tshc_pkg::N_GRP{tshc_pkg::OFF_RST}};
            cfg_r.ar_en <= '1;
            pend_r <= '0;
            pend_v_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            pend_r <= pend_nxt;
            pend_v_r <= pend_v_nxt;
            refused_r <= refused_nxt;
        end
    end

    // heater pwm: free running, shared timebase, independent per source
    always_comb begin
        pre_nxt = pre_r + 32'h0000_0001;
        phase_nxt = phase_r;
        if (pre_r >= 32'(PWM_PRESCALE - 1)) begin
            pre_nxt = '0;
            phase_nxt = (phase_r >= 12'(tshc_pkg::DUTY_STEPS - 1)) ? 12'h000 : phase_r + 12'h001;
        end
        otf_nxt = otf_r;
        for (int s = 0; s < 2; s++) begin
            if (cfg_r.const_pwr[s]) begin
                // duty = (setpoint - zero) / steps, saturating at both ends
                heat_nxt[s] = cfg_r.setpoint[s] > tshc_pkg::SP_ZERO
                    && (cfg_r.setpoint[s] - tshc_pkg::SP_ZERO) > phase_r;
            end else begin
                heat_nxt[s] = i_pid_heat[s];
            end
            // comparator hysteresis is analog; drive follows it directly
            if (i_overtemp[s]) begin
                heat_nxt[s] = 1'b0;
            end
            if (i_cmd_valid) begin
                otf_nxt[s] = 1'b0;
            end
            if (i_overtemp[s]) begin
                otf_nxt[s] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pre_r <= '0;
            phase_r <= '0;
            heat_r <= '0;
            otf_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            phase_r <= phase_nxt;
            heat_r <= heat_nxt;
            otf_r <= otf_nxt;
        end
    end

    assign o_mux_ch = ch;
    assign o_offset = off;
    assign o_adc_start = start_r;
    assign o_result = res_r;
    assign o_scan_done = (state_r == tshc_pkg::S_END);
    assign o_cfg = cfg_r;
    assign o_cmd_refused = refused_r;
    assign o_heater = heat_r;
    assign o_overtemp_flag = otf_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence seq_last_conv;
        state_r == tshc_pkg::S_CONV && i_adc_valid && cnt_r == '1;
    endsequence
    sequence seq_store;
        state_r == tshc_pkg::S_STORE;
    endsequence

    AST_THERM_HOLD: assert property ($changed(o_cfg.therm_b) |-> $past(state_r) == tshc_pkg::S_END)
        else $error("thermistor selection changed outside end of interval");
    AST_PWM_PHASE: assert property (phase_r < 12'(tshc_pkg::DUTY_STEPS))
        else $error("pwm phase out of range");
    AST_ZERO_DUTY: assert property (cfg_r.const_pwr[0] && cfg_r.setpoint[0] <= tshc_pkg::SP_ZERO |=> !o_heater[0])
        else $error("heater on at zero duty set point");
    AST_FULL_DUTY: assert property (cfg_r.const_pwr[1] && cfg_r.setpoint[1] >= tshc_pkg::SP_FULL && !i_overtemp[1] |=> o_heater[1])
        else $error("heater off at full duty set point");
    AST_OT_CUT: assert property (i_overtemp[0] |=> !o_heater[0] && o_overtemp_flag[0])
        else $error("overtemperature did not cut heater");
    AST_OT_HOLD: assert property (o_overtemp_flag[1] && !i_cmd_valid |=> o_overtemp_flag[1])
        else $error("overtemperature indicator dropped");
    AST_OT_INDEP: assert property (i_overtemp == 2'b01 && !o_overtemp_flag[1] && !i_cmd_valid |=> !o_overtemp_flag[1])
        else $error("overtemperature crossed between sources");
    AST_AVG_STORE: assert property (seq_last_conv ##1 seq_store |=> o_result[$past(slot_r)] == $past(sum_r[tshc_pkg::SUM_W-1 -: 16]))
        else $error("average not stored");
    AST_CAL_SECOND: assert property (slot_r == 5'(tshc_pkg::SLOT_SECOND) |-> o_mux_ch == tshc_pkg::CH_CAL_A && o_offset == 3'h2)
        else $error("second calibration pass wrong");
    AST_AR_STEP: assert property (state_r == tshc_pkg::S_END && !pend_v_r && cfg_r.offset[0] <= tshc_pkg::OFF_MAX_AR |=> o_cfg.offset[0] <= tshc_pkg::OFF_MAX_AR)
        else $error("autorange left codes 0 to 3");
endmodule
`default_nettype wire

// *** testbench/tshc_fe_model.sv ***
// adc and multiplexer front end model answering conversion requests
`timescale 1ns/1ps
`default_nettype none
module tshc_fe_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // conversion request
    input wire logic i_start,
    input wire logic [3:0] i_ch,
    input wire logic [2:0] i_off,
    input wire logic [15:0][15:0] i_base,
    // conversion answer
    output logic o_valid,
    output logic signed [15:0] o_data
);
    int wait_n = -1;
    logic [15:0] last = 16'h0000;
    initial begin
        o_valid = 1'b0;
        o_data = 16'h0000;
    end
    // latency varies per request; between answers the data line shows junk, not the last value
    always @(posedge i_clk) begin
        o_valid <= 1'b0;
        o_data <= ~last;
        if (!i_resetn) begin
            wait_n = -1;
        end else if (i_start) begin
            wait_n = $urandom % 2;
        end else if (wait_n > 0) begin
            wait_n = wait_n - 1;
        end
        if (wait_n == 0) begin
            last = i_base[i_ch] + 16'(i_off);
            o_valid <= 1'b1;
            o_data <= last;
            wait_n = -1;
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the scan sequencer with an integer reference model
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic [1:0] i_pid_heat = 2'b00;
    logic [1:0] i_overtemp = 2'b00;
    logic i_adc_valid;
    logic signed [15:0] i_adc_data;
    tshc_pkg::tshc_cfg_t i_cmd = '0;
    tshc_pkg::tshc_cfg_t o_cfg, m_cfg, pend, cq;
    logic o_cmd_refused, o_adc_start, o_scan_done, m_ref, pend_v, apply_chk, rq;
    logic [3:0] o_mux_ch;
    logic [2:0] o_offset;
    logic [18:0][15:0] o_result;
    logic [1:0] o_heater, o_overtemp_flag, pq, oq;
    logic [15:0][15:0] base;
    int m_off[5];
    int errors = 0;
    int checks_done = 0;
    int nconv = 0;
    int hi0 = 0;
    int hi1 = 0;

    tshc_scan #(.SETTLE_CYC(4), .PWM_PRESCALE(2)) DUT (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .o_cmd_refused(o_cmd_refused), .o_cfg(o_cfg), .o_mux_ch(o_mux_ch),
        .o_offset(o_offset), .o_adc_start(o_adc_start), .i_adc_valid(i_adc_valid),
        .i_adc_data(i_adc_data), .o_result(o_result), .o_scan_done(o_scan_done),
        .i_pid_heat(i_pid_heat), .i_overtemp(i_overtemp), .o_heater(o_heater),
        .o_overtemp_flag(o_overtemp_flag));
    tshc_fe_model fe (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_start(o_adc_start), .i_ch(o_mux_ch),
        .i_off(o_offset), .i_base(base), .o_valid(i_adc_valid), .o_data(i_adc_data));

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) i_pid_heat <= 2'($urandom);

    function automatic logic ok(input logic c);
        checks_done++;
        if (c !== 1'b1) errors++;
        return c === 1'b1;
    endfunction
    function automatic logic cfg_ok();
        return o_cfg.setpoint === m_cfg.setpoint && o_cfg.therm_b === m_cfg.therm_b
            && o_cfg.const_pwr === m_cfg.const_pwr;
    endfunction
    function automatic int slot_ch(input int s);
        return s < 16 ? s : s - 4;
    endfunction
    function automatic int slot_off(input int s);
        if (s > 15) return 18 - s;
        if (s > 11) return 15 - s;
        if (s == 11) return 3;
        if (s > 7) return m_off[s - 6];
        return m_off[s / 4];
    endfunction

    // reference model: slot order, offsets, averages, command apply, autorange
    always @(negedge i_clk) begin
        int r;
        int gs;
        if (!i_resetn) nconv = 0;
        hi0 += int'(o_heater[0]);
        hi1 += int'(o_heater[1]);
        if (rq && i_resetn) begin
            for (int s = 0; s < 2; s++) begin
                if ((!cq.const_pwr[s] || oq[s]) && !ok(o_heater[s] === (pq[s] & ~oq[s] & ~cq.const_pwr[s])))
                    $display("mismatch at %0t: heater %0d", $time, s);
            end
        end
        if (o_adc_start === 1'b1) begin
            if (!ok(o_mux_ch === 4'(slot_ch(nconv / 256)) && o_offset === 3'(slot_off(nconv / 256))))
                $display("mismatch at %0t: channel or offset", $time);
            nconv++;
        end
        if (apply_chk) begin
            apply_chk = 1'b0;
            if (!ok(cfg_ok() && o_cmd_refused === m_ref)) $display("mismatch at %0t: apply", $time);
        end
        if (o_scan_done === 1'b1) begin
            if (!ok(nconv == 4864 && cfg_ok())) $display("mismatch at %0t: scan", $time);
            for (int s = 0; s < 19; s++) begin
                if (!ok(o_result[s] === base[slot_ch(s)] + 16'(slot_off(s))))
                    $display("mismatch at %0t: result slot %0d", $time, s);
            end
            nconv = 0;
            m_ref = 1'b0;
            if (pend_v) begin
                pend_v = 1'b0;
                for (int s = 0; s < 2; s++) begin
                    if (!pend.const_pwr[s] && (pend.setpoint[s] < tshc_pkg::SP_AMB_MIN
                        || pend.setpoint[s] > tshc_pkg::SP_AMB_MAX)) begin
                        pend.setpoint[s] = m_cfg.setpoint[s];
                        m_ref = 1'b1;
                    end
                end
                m_cfg = pend;
                for (int g = 0; g < 5; g++) m_off[g] = pend.offset[g];
            end else begin
                // autorange only on groups inside codes 0 to 3, one step per scan
                for (int g = 0; g < 5; g++) begin
                    gs = g < 2 ? 4 * g : g + 6;
                    r = $signed(base[slot_ch(gs)]) + slot_off(gs);
                    if (m_cfg.ar_en[g] && m_off[g] < 4) begin
                        if (r < -28672 && m_off[g] < 3) m_off[g]++;
                        else if (r > 28672 && m_off[g] > 0) m_off[g]--;
                    end
                end
            end
            apply_chk = 1'b1;
        end
        pq = i_pid_heat;
        oq = i_overtemp;
        cq = o_cfg;
        rq = i_resetn;
    end

    task automatic send(input tshc_pkg::tshc_cfg_t c);
        @(posedge i_clk);
        i_cmd <= c;
        i_cmd_valid <= 1'b1;
        pend = c;
        pend_v = 1'b1;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
    endtask
    task automatic wait_done();
        @(negedge i_clk);
        while (o_scan_done !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
    endtask
    // one full pwm period: 3900 steps of two cycles
    task automatic duty(input int e0, input int e1);
        @(posedge i_clk);
        hi0 = 0;
        hi1 = 0;
        repeat (7800) @(posedge i_clk);
        if (!ok(hi0 == e0 && (e1 < 0 || hi1 == e1))) $display("mismatch at %0t: duty", $time);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (200000) @(posedge i_clk);
        errors++;
        test_done();
    end

    initial begin
        tshc_pkg::tshc_cfg_t c;
        void'($urandom(32'h25E0));
        {pend_v, apply_chk, rq, m_ref} = 4'h0;
        m_cfg = '0;
        m_cfg.setpoint = {tshc_pkg::SP_HOT_RST, tshc_pkg::SP_AMB_RST};
        m_cfg.ar_en = 5'h1F;
        for (int g = 0; g < 5; g++) m_off[g] = 1;
        for (int ch = 0; ch < 16; ch++) base[ch] = 16'($urandom_range(40000)) - 16'h4E20;
        // extremes push the autorange groups and show calibration offsets stay fixed
        base[0] = 16'h8AD0;
        base[4] = 16'h7530;
        base[8] = 16'h7530;
        base[11] = 16'h8300;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_overtemp <= 2'b01;
        repeat (3) @(posedge i_clk);
        i_overtemp <= 2'b00;
        repeat (3) @(negedge i_clk);
        if (!ok(o_overtemp_flag === 2'b01)) $display("mismatch at %0t: flag set", $time);
        c = m_cfg;
        c.therm_b = 2'($urandom);
        c.setpoint[0] = 12'($urandom_range(3740)) + 12'h0_064;
        c.setpoint[1] = 12'h0_F80;
        c.offset = {3'h4, 3'h0, 3'h3, 3'h1, 3'h1};
        c.ar_en = 5'h07;
        send(c);
        @(negedge i_clk);
        if (!ok(o_overtemp_flag === 2'b00)) $display("mismatch at %0t: flag clear", $time);
        wait_done();
        wait_done();
        c = m_cfg;
        c.const_pwr = 2'b11;
        c.setpoint = {12'h0_FA0, 12'h0_802};
        for (int g = 0; g < 5; g++) c.offset[g] = 3'($urandom % 5);
        c.ar_en = 5'($urandom);
        send(c);
        wait_done();
        duty(3900, 7800);
        wait_done();
        c = m_cfg;
        c.const_pwr = 2'b01;
        c.setpoint = {12'h0_050, 12'h0_064};
        send(c);
        wait_done();
        duty(0, -1);
        test_done();
    end
endmodule
`default_nettype wire
